// ==== design/mpf_defines.svh ====
// Register offsets, field positions, reset values and fault codes for the permission checker
`ifndef MPF_DEFINES_SVH
`define MPF_DEFINES_SVH
`define MPF_OFF_DOMAIN 12'h000
`define MPF_OFF_CTRL 12'h004
`define MPF_OFF_FSTAT 12'h008
`define MPF_OFF_FADDR 12'h00C
`define MPF_OFF_CAPCNT 12'h010
`define MPF_RST_DOMAIN 32'h0000_0000
`define MPF_RST_CTRL 32'h0000_0000
`define MPF_CTRL_ALIGN 1
`define MPF_CTRL_PROT 8
`define MPF_CTRL_ROMP 9
`define MPF_FC_ALIGN 4'h1
`define MPF_FC_SEC_XLT 4'h5
`define MPF_FC_PG_XLT 4'h7
`define MPF_FC_SEC_DOM 4'h9
`define MPF_FC_PG_DOM 4'hB
`define MPF_FC_SEC_PERM 4'hD
`define MPF_FC_PG_PERM 4'hF
`define MPF_FC_NONE 4'h0
`endif

// ==== design/mpf_pkg.sv ====
// Types shared by the permission checker
package mpf_pkg;
  typedef enum logic [1:0] {
    MPF_DOM_NONE = 2'b00,
    MPF_DOM_CLIENT = 2'b01,
    MPF_DOM_RSVD = 2'b10,
    MPF_DOM_MANAGER = 2'b11
  } mpf_dom_e;
  typedef enum logic [1:0] {
    MPF_L2_INVALID = 2'b00,
    MPF_L2_LARGE = 2'b01,
    MPF_L2_SMALL = 2'b10,
    MPF_L2_RSVD = 2'b11
  } mpf_l2_e;
  typedef struct packed {
    logic [31:0] vaddr;
    logic [31:0] l1_desc;
    logic [31:0] l2_desc;
    logic supervisor;
    logic write;
    logic data;
    logic word;
  } mpf_req_s;
  typedef struct packed {
    logic [31:0] paddr;
    logic cacheable;
    logic bufferable;
    logic mem_go;
    logic abort;
    logic [3:0] fault_code;
    logic [3:0] domain;
  } mpf_rsp_s;
endpackage

// ==== design/mpf_checker.sv ====
// Access-permission and fault logic with AHB-Lite register slave
//
// Contract
// - Code 00, S=0 R=0: fault all; S=1 R=0: supervisor read only.
// - Code 00, S=0 R=1: reads allowed both modes, writes fault; S=R=1 reserved.
// - Code 01: supervisor read/write, every user access faults.
// - Code 10: supervisor read/write, user read only, user write faults.
// - Code 11: read and write allowed in both modes.
// - Permission check completes before a physical address is issued.
// - Entry bits 1:0: 00 invalid, 01 large, 10 small, 11 reserved.
// - Entry bit 2 is bufferable, bit 3 is cacheable.
// - Entry bits 11:4 hold four 2-bit subpage permission codes.
// - Page number from entry 31:12 small, 31:16 large; low bits from address.
// - Any violation suppresses the memory cycle and aborts the processor.
// - Data abort loads fault code, domain and faulting virtual address.
// - Prefetch abort only tags the instruction; fault registers unchanged.
// - Only highest priority fault is reported, alignment first, page permission last.
// - Codes: 0001, 0101, 0111, 1001, 1011, 1101, 1111.
// - Section translation fault reports first-level bits 8:5 as domain.
// - Sixteen 2-bit domain settings in one register, domain n at 2n+1:2n.
// - Domain setting 00 faults any access.
// - Domain setting 01 checks the permission code.
// - Domain setting 10 behaves as 00.
// - Domain setting 11 skips the permission check.
// - First-level bits 8:5 select the governing domain setting.
// - Protection bit is control bit 8, ROM-protect bit is control bit 9.
// - Subpage code chosen by page quarter; top quarter uses highest code.
// - Misaligned data word access faults when alignment checking enabled.
`include "mpf_defines.svh"
module mpf_checker
  import mpf_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic req_valid,
  input wire mpf_req_s req,
  output mpf_rsp_s rsp
);

  // Permission table lookup for one code
  function automatic logic perm_ok(input logic [1:0] code, input logic prot,
                                   input logic romp, input logic sup,
                                   input logic wr);
    logic ok;
    ok = 1'b0;
    unique case (code)
      2'b00: begin
        if (!prot && !romp) begin
          ok = 1'b0;
        end else if (prot && !romp) begin
          ok = sup && !wr;
        end else if (!prot && romp) begin
          ok = !wr;
        end else begin
          ok = 1'b0;
        end
      end
      2'b01: ok = sup;
      2'b10: ok = sup || !wr;
      2'b11: ok = 1'b1;
    endcase
    return ok;
  endfunction

  // Domain settings: 00 and 10 fault, 01 checks, 11 passes
  function automatic logic dom_fault(input logic [1:0] setting);
    return (setting == MPF_DOM_NONE) || (setting == MPF_DOM_RSVD);
  endfunction

  logic [31:0] domain_q;
  logic [31:0] ctrl_q;
  logic [7:0] fstat_q;
  logic [31:0] faddr_q;
  logic [15:0] capcnt_q;

  logic prot;
  logic romp;
  logic [3:0] dom_idx;
  logic [1:0] dom_set;
  logic is_section;
  logic l1_bad;
  logic l2_bad;
  logic [1:0] sub_code;
  logic align_f;
  logic f_sec_dom;
  logic f_pg_dom;
  logic f_sec_perm;
  logic f_pg_perm;
  logic [3:0] code;
  logic [31:0] paddr;
  mpf_l2_e l2_kind;

  assign prot = ctrl_q[`MPF_CTRL_PROT];
  assign romp = ctrl_q[`MPF_CTRL_ROMP];
  assign dom_idx = req.l1_desc[8:5];
  assign dom_set = domain_q[{dom_idx, 1'b0} +: 2];
  assign is_section = (req.l1_desc[1:0] == 2'b10);
  assign l1_bad = (req.l1_desc[1:0] == 2'b00) || (req.l1_desc[1:0] == 2'b11);
  assign l2_kind = mpf_l2_e'(req.l2_desc[1:0]);
  assign l2_bad = (l2_kind == MPF_L2_INVALID) || (l2_kind == MPF_L2_RSVD);

  // Subpage permission chosen by page quarter
  always_comb begin
    if (l2_kind == MPF_L2_LARGE) begin
      sub_code = req.l2_desc[{req.vaddr[15:14], 1'b0} + 4 +: 2];
    end else begin
      sub_code = req.l2_desc[{req.vaddr[11:10], 1'b0} + 4 +: 2];
    end
  end

  // Individual fault sources
  assign align_f = ctrl_q[`MPF_CTRL_ALIGN] && req.data && req.word
                   && (req.vaddr[1:0] != 2'b00);
  assign f_sec_dom = is_section && dom_fault(dom_set);
  assign f_pg_dom = !is_section && dom_fault(dom_set);
  assign f_sec_perm = is_section && (dom_set == MPF_DOM_CLIENT)
                      && !perm_ok(req.l1_desc[11:10], prot, romp,
                                  req.supervisor, req.write);
  assign f_pg_perm = !is_section && (dom_set == MPF_DOM_CLIENT)
                     && !perm_ok(sub_code, prot, romp, req.supervisor, req.write);

  // Priority encoder, highest first
  always_comb begin
    if (align_f) begin
      code = `MPF_FC_ALIGN;
    end else if (l1_bad) begin
      code = `MPF_FC_SEC_XLT;
    end else if (!is_section && l2_bad) begin
      code = `MPF_FC_PG_XLT;
    end else if (f_sec_dom) begin
      code = `MPF_FC_SEC_DOM;
    end else if (f_pg_dom) begin
      code = `MPF_FC_PG_DOM;
    end else if (f_sec_perm) begin
      code = `MPF_FC_SEC_PERM;
    end else if (f_pg_perm) begin
      code = `MPF_FC_PG_PERM;
    end else begin
      code = `MPF_FC_NONE;
    end
  end

  // Physical address by mapping size
  always_comb begin
    if (is_section) begin
      paddr = {req.l1_desc[31:20], req.vaddr[19:0]};
    end else if (l2_kind == MPF_L2_LARGE) begin
      paddr = {req.l2_desc[31:16], req.vaddr[15:0]};
    end else begin
      paddr = {req.l2_desc[31:12], req.vaddr[11:0]};
    end
  end

  // Registered answer to the processor, one cycle after the request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rsp <= '0;
    end else if (req_valid) begin
      rsp.abort <= (code != `MPF_FC_NONE);
      rsp.mem_go <= (code == `MPF_FC_NONE);
      rsp.paddr <= (code == `MPF_FC_NONE) ? paddr : 32'h0000_0000;
      rsp.fault_code <= code;
      rsp.domain <= dom_idx;
      rsp.bufferable <= is_section ? req.l1_desc[2] : req.l2_desc[2];
      rsp.cacheable <= is_section ? req.l1_desc[3] : req.l2_desc[3];
    end else begin
      rsp.abort <= 1'b0;
      rsp.mem_go <= 1'b0;
    end
  end

  // AHB-Lite address phase capture
  logic wr_pend_q;
  logic rd_pend_q;
  logic [11:0] addr_q;
  logic take;
  assign take = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 12'h000;
    end else if (hready) begin
      wr_pend_q <= take && hwrite;
      rd_pend_q <= take && !hwrite;
      addr_q <= haddr[11:0];
    end
  end

  // Domain and control registers, written by software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      domain_q <= `MPF_RST_DOMAIN;
      ctrl_q <= `MPF_RST_CTRL;
    end else if (wr_pend_q) begin
      if (addr_q == `MPF_OFF_DOMAIN) begin
        domain_q <= hwdata;
      end
      if (addr_q == `MPF_OFF_CTRL) begin
        ctrl_q <= hwdata & 32'h0000_0302;
      end
    end
  end

  // Fault capture on data aborts only; capture beats a software write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fstat_q <= 8'h00;
      faddr_q <= 32'h0000_0000;
      capcnt_q <= 16'h0000;
    end else if (req_valid && req.data && (code != `MPF_FC_NONE)) begin
      fstat_q <= {dom_idx, code};
      faddr_q <= req.vaddr;
      capcnt_q <= capcnt_q + 16'h0001;
    end else if (wr_pend_q && addr_q == `MPF_OFF_FSTAT) begin
      fstat_q <= hwdata[7:0];
    end else if (wr_pend_q && addr_q == `MPF_OFF_FADDR) begin
      faddr_q <= hwdata;
    end
  end

  // Read data mux, unmapped reads zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      unique case (haddr[11:0])
        `MPF_OFF_DOMAIN: hrdata <= domain_q;
        `MPF_OFF_CTRL: hrdata <= ctrl_q;
        `MPF_OFF_FSTAT: hrdata <= {24'h000000, fstat_q};
        `MPF_OFF_FADDR: hrdata <= faddr_q;
        `MPF_OFF_CAPCNT: hrdata <= {16'h0000, capcnt_q};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  logic unused_ok;
  assign unused_ok = ^{hsize, rd_pend_q, haddr[31:12]};

endmodule

// ==== verif/mpf_core_model.sv ====
// Core model presenting one access per call
module mpf_core_model
  import mpf_pkg::*;
(
  input wire logic hclk,
  output logic req_valid,
  output mpf_req_s req
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle at start
  initial req_valid = 1'b0;
  initial req = '0;
  // One cycle request with mode, direction and kind, then released
  task automatic issue(input mpf_req_s r);
    @(posedge hclk);
    req <= r;
    req_valid <= 1'b1;
    @(posedge hclk);
    req_valid <= 1'b0;
    req <= ~r;
  endtask
endmodule

// ==== verif/mpf_checker_props.sv ====
// Port checks for the permission checker
module mpf_checker_props
  import mpf_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic req_valid,
  input wire mpf_req_s req,
  input wire mpf_rsp_s rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mis;
  logic pg;
  // Misaligned word access and page walk flags
  assign mis = req.data & req.word & (req.vaddr[1:0] != 2'b00);
  assign pg = req_valid & (req.l1_desc[1:0] == 2'b01) & ~mis;
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  property p_one; req_valid |=> rsp.abort != rsp.mem_go; endproperty
  a_one: assert property (p_one) else $error("abort go clash");
  property p_nopa; rsp.abort |-> rsp.paddr == 32'h0; endproperty
  a_nopa: assert property (p_nopa) else $error("address on abort");
  property p_sx; req_valid && !mis && req.l1_desc[1:0] == 2'b00
    |=> rsp.fault_code == 4'h5 && rsp.domain == $past(req.l1_desc[8:5]); endproperty
  a_sx: assert property (p_sx) else $error("section xlt");
  property p_px; pg && req.l2_desc[1:0] == 2'b00 |=> rsp.abort && rsp.fault_code == 4'h7;
  endproperty
  a_px: assert property (p_px) else $error("page xlt");
  property p_al; rsp.abort && rsp.fault_code == 4'h1 |-> $past(mis); endproperty
  a_al: assert property (p_al) else $error("align");
  property p_sm; pg && req.l2_desc[1:0] == 2'b10 ##1 rsp.mem_go
    |-> rsp.paddr == {$past(req.l2_desc[31:12]), $past(req.vaddr[11:0])}; endproperty
  a_sm: assert property (p_sm) else $error("small addr");
  property p_lg; pg && req.l2_desc[1:0] == 2'b01 ##1 rsp.mem_go
    |-> rsp.paddr == {$past(req.l2_desc[31:16]), $past(req.vaddr[15:0])}; endproperty
  a_lg: assert property (p_lg) else $error("large addr");
  property p_cb; pg && req.l2_desc[1] != req.l2_desc[0] ##1 rsp.mem_go
    |-> {rsp.cacheable, rsp.bufferable} == $past(req.l2_desc[3:2]); endproperty
  a_cb: assert property (p_cb) else $error("attr");
  property p_scb; req_valid && req.l1_desc[1:0] == 2'b10 && !mis ##1 rsp.mem_go
    |-> {rsp.cacheable, rsp.bufferable} == $past(req.l1_desc[3:2]); endproperty
  a_scb: assert property (p_scb) else $error("section attr");
endmodule

// ==== verif/mpf_checker_tb_top.sv ====
// Self-checking bench for the permission checker
module mpf_checker_tb_top
  import mpf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, req_valid;
  mpf_req_s req;
  mpf_rsp_s rsp;
  int fail_count = 0;
  int tests_run = 0;
  // 125 MHz clock
  always #4 hclk = ~hclk;
  // Block and core model
  mpf_checker mpf_checker_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .req_valid(req_valid),
    .req(req), .rsp(rsp));
  mpf_core_model mpf_core_model_i (.hclk(hclk), .req_valid(req_valid), .req(req));
  // Verdict
  task automatic stop_test();
    if (fail_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Compare one value
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  // Bounded wait for ready
  task automatic wait_rdy();
    for (int n = 0; n < 20; n++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) return;
    end
    fail_count++;
    stop_test();
  endtask
  // One word transfer; a read is compared with d
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {20'h0, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    if (!wr) chk("reg", d, hrdata);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  // Access builder, data word by default
  function automatic mpf_req_s rq(input logic [31:0] v, l1, l2, input logic s, w,
    input logic d = 1'b1, input logic k = 1'b1);
    rq = '{v, l1, l2, s, w, d, k};
  endfunction
  // One access; code 0 means allowed
  task automatic acc(input mpf_req_s r, input logic [3:0] c, input string n);
    mpf_core_model_i.issue(r);
    #1;
    chk(n, {24'h0, c, 2'b00, c != 4'h0, c == 4'h0},
      {24'h0, rsp.abort ? rsp.fault_code : 4'h0, 2'b00, rsp.abort, rsp.mem_go});
  endtask
  // Control reset value, writable bits, unmapped place, domain layout
  task automatic regs();
    bus(1'b0, 12'h004, 32'h0);
    bus(1'b1, 12'h004, 32'hFFFF_FFFF);
    bus(1'b0, 12'h004, 32'h0000_0302);
    bus(1'b1, 12'h020, 32'h5A5A_5A5A);
    bus(1'b0, 12'h020, 32'h0);
    bus(1'b1, 12'h000, 32'h0000_00E1);
    bus(1'b0, 12'h000, 32'h0000_00E1);
  endtask
  // Section codes against mode, direction and control bits
  task automatic perms();
    logic e;
    for (int c = 0; c < 3; c++) begin
      bus(1'b1, 12'h004, {22'h0, c[1:0], 8'h0});
      for (int i = 0; i < 16; i++) begin
        case (i[3:2])
          2'b00: e = !i[0] && ((c == 1 && i[1]) || c == 2);
          2'b01: e = i[1];
          2'b10: e = i[1] || !i[0];
          default: e = 1'b1;
        endcase
        acc(rq(32'h100, {12'h123, 8'h0, i[3:2], 10'h01E}, 32'h0, i[1], i[0]),
          e ? 4'h0 : 4'hD, "perm");
      end
    end
  endtask
  // Domain settings and priority
  task automatic doms();
    acc(rq(32'h100, 32'hC32, 32'h0, 1'b1, 1'b0), 4'h9, "d00");
    acc(rq(32'h100, 32'hC52, 32'h0, 1'b1, 1'b0), 4'h9, "d10");
    acc(rq(32'h100, 32'h072, 32'h0, 1'b0, 1'b1), 4'h0, "d11");
    acc(rq(32'h100, 32'h031, 32'hFF2, 1'b1, 1'b0), 4'hB, "pdom");
    acc(rq(32'h100, 32'h030, 32'h0, 1'b1, 1'b0), 4'h5, "prio");
  endtask
  // Quarter codes of small and large pages, user writes
  task automatic pages();
    for (int i = 0; i < 8; i++) begin
      acc(rq(i[2] ? {16'h0, i[1:0], 14'h24} : {20'h0, i[1:0], 10'h24}, 32'h11,
        {16'hABCD, 4'h0, 8'hE4, 2'b11, i[2] ? 2'b01 : 2'b10}, 1'b0, 1'b1),
        i[1:0] == 2'b11 ? 4'h0 : 4'hF, "sub");
    end
    acc(rq(32'h100, 32'h11, 32'hFF0, 1'b1, 1'b0), 4'h7, "pxlt");
  endtask
  // Alignment, capture and prefetch aborts
  task automatic faults();
    bus(1'b1, 12'h004, 32'h0000_0002);
    acc(rq(32'h1003, 32'h32, 32'h0, 1'b1, 1'b0), 4'h1, "algn");
    bus(1'b0, 12'h00C, 32'h0000_1003);
    acc(rq(32'h2000, 32'h153, 32'h0, 1'b1, 1'b0), 4'h5, "sxlt");
    bus(1'b0, 12'h008, 32'h0000_00A5);
    acc(rq(32'h3000, 32'h0, 32'h0, 1'b1, 1'b0, 1'b0), 4'h5, "pf");
    bus(1'b0, 12'h008, 32'h0000_00A5);
    bus(1'b0, 12'h00C, 32'h0000_2000);
    acc(rq(32'h1002, 32'hC12, 32'h0, 1'b1, 1'b0, 1'b0), 4'h0, "ifa");
    acc(rq(32'h1002, 32'hC12, 32'h0, 1'b1, 1'b0, 1'b1, 1'b0), 4'h0, "byte");
    // Capture count: 18 perms, 4 domain, 7 page and 2 data aborts here; fetches excluded
    bus(1'b0, 12'h010, 32'h0000_001F);
  endtask
  // Reset for ten cycles, then the scenarios
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    regs();
    perms();
    doms();
    pages();
    faults();
    stop_test();
  end
endmodule
bind mpf_checker mpf_checker_props mpf_checker_props_i (.hclk(hclk), .hresetn(hresetn),
  .req_valid(req_valid), .req(req), .rsp(rsp));
